// file: dv/flwl_flash_model.sv
// Flash array model: answers strobed byte reads from an eight byte image.
// Assumes the loader holds strobe and address until acknowledge.
module flwl_flash_model (
    input  wire         clk_i,
    input  wire         flash_rd_i,
    input  wire  [19:0] flash_addr_i,
    input  wire  [63:0] image_i,
    input  wire  [3:0]  lat_i,
    input  wire         mute_i,
    output logic [7:0]  flash_rdata_o = 8'h00,
    output logic        flash_ack_o   = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg = 4'h0;

    // ----------------------------------------------------------------
    // Read answer after lat_i cycles, never when muted
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        flash_ack_o <= 1'b0;
        flash_rdata_o <= ~flash_rdata_o;
        wait_reg <= 4'h0;
        if (flash_rd_i && !flash_ack_o) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == lat_i && !mute_i) begin
                flash_ack_o <= 1'b1;
                flash_rdata_o <= (flash_addr_i[19:3] == 17'h1ffff) ?
                                 image_i[flash_addr_i[2:0]*8 +: 8] : 8'h00;
            end
        end
    end
endmodule

// file: dv/flwl_loader_asserts.sv
// Port checker of the setup word loader, bound to its top module.
// Assumes one clock clk_i and synchronous active-high srst_i.
module flwl_loader_asserts #(
    parameter [11:0] FCW_PAGE = 12'hfff
) (
    input wire        clk_i,
    input wire        srst_i,
    input wire        prog_rd_i,
    input wire        prog_wr_i,
    input wire [21:0] prog_addr_i,
    input wire [7:0]  prog_rdata_o,
    input wire        prog_hit_o,
    input wire        wr_ignored_o,
    input wire        flash_rd_o,
    input wire [19:0] flash_addr_o,
    input wire        flash_ack_i,
    input wire        cpu_hold_o,
    input wire        load_done_o,
    input wire [63:0] all_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [3:0] rd_cnt_reg;
    logic [7:0] exp_reg;
    wire        hit_w = (prog_addr_i[21:3] == 19'h60000);

    always @(posedge clk_i) begin
        rd_cnt_reg <= srst_i ? 4'h0 : rd_cnt_reg + {3'h0, $rose(flash_rd_o)};
        exp_reg <= all_i[prog_addr_i[2:0]*8 +: 8];
    end

    nibble_zero_a: assert property (
        {all_i[15:12], all_i[31:28], all_i[47:44], all_i[63:60]} == 16'h0000)
        else $error("high setup nibble not zero");
    load_start_a: assert property ($fell(srst_i) |-> ##[1:2] flash_rd_o)
        else $error("load did not start after reset");
    fetch_order_a: assert property ($rose(flash_rd_o) |-> rd_cnt_reg < 4'h8 &&
        flash_addr_o == {FCW_PAGE, 5'h1f, rd_cnt_reg[2:0]})
        else $error("flash fetch out of order");
    strobe_drop_a: assert property (flash_rd_o && flash_ack_i |=> !flash_rd_o)
        else $error("flash strobe held after acknowledge");
    hold_pair_a: assert property (cpu_hold_o == !load_done_o)
        else $error("hold and done disagree");
    no_reload_a: assert property (load_done_o |-> !flash_rd_o)
        else $error("flash read after load done");
    bytes_frozen_a: assert property (load_done_o |=> $stable(all_i))
        else $error("setup bytes changed after load");
    read_back_a: assert property (prog_rd_i && hit_w |=>
        prog_hit_o && prog_rdata_o == exp_reg)
        else $error("setup read returned wrong byte");
    unmapped_zero_a: assert property (prog_rd_i && !hit_w |=>
        !prog_hit_o && prog_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    write_drop_a: assert property (prog_wr_i && hit_w |=> wr_ignored_o)
        else $error("setup write not flagged as dropped");
    cover property ($rose(load_done_o));
    cover property ((flash_rd_o && !flash_ack_i) [*8]);
    cover property (wr_ignored_o);
endmodule

bind flwl_loader flwl_loader_asserts #(.FCW_PAGE(FCW_PAGE)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
    .prog_addr_i(prog_addr_i), .prog_rdata_o(prog_rdata_o), .prog_hit_o(prog_hit_o),
    .wr_ignored_o(wr_ignored_o), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
    .flash_ack_i(flash_ack_i), .cpu_hold_o(cpu_hold_o), .load_done_o(load_done_o),
    .all_i({setup_byte_4_high_o, setup_byte_4_low_o, setup_byte_3_high_o, setup_byte_3_low_o,
            setup_byte_2_high_o, setup_byte_2_low_o, setup_byte_1_high_o, setup_byte_1_low_o}));

// file: dv/flwl_loader_bench.sv
// Self-checking bench of the setup word loader against a flash model.
// Assumes a 50 ns clock and the loader with its default parameters.
module flwl_loader_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, srst_i, prog_rd_i, prog_wr_i, mute;
    logic        prog_hit_o, wr_ignored_o, flash_rd_o, flash_ack_i;
    logic        cpu_hold_o, load_done_o, load_err_o;
    logic [21:0] prog_addr_i;
    logic [19:0] flash_addr_o;
    logic [7:0]  prog_wdata_i, prog_rdata_o, flash_rdata_i;
    logic [63:0] image;
    wire  [63:0] sb;
    logic [3:0]  lat;
    int          errors, checks_done;

    flwl_loader dut (.clk_i(clk_i), .srst_i(srst_i), .prog_rd_i(prog_rd_i),
        .prog_wr_i(prog_wr_i), .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i),
        .prog_rdata_o(prog_rdata_o), .prog_hit_o(prog_hit_o), .wr_ignored_o(wr_ignored_o),
        .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_rdata_i(flash_rdata_i),
        .flash_ack_i(flash_ack_i), .cpu_hold_o(cpu_hold_o), .load_done_o(load_done_o),
        .load_err_o(load_err_o), .setup_byte_1_low_o(sb[7:0]), .setup_byte_1_high_o(sb[15:8]),
        .setup_byte_2_low_o(sb[23:16]), .setup_byte_2_high_o(sb[31:24]),
        .setup_byte_3_low_o(sb[39:32]), .setup_byte_3_high_o(sb[47:40]),
        .setup_byte_4_low_o(sb[55:48]), .setup_byte_4_high_o(sb[63:56]));
    flwl_flash_model flash (.clk_i(clk_i), .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
        .image_i(image), .lat_i(lat), .mute_i(mute), .flash_rdata_o(flash_rdata_i),
        .flash_ack_o(flash_ack_i));

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [21:0] a, input logic [7:0] exp, input logic hit);
        @(posedge clk_i);
        prog_rd_i <= 1'b1;
        prog_addr_i <= a;
        @(posedge clk_i);
        prog_rd_i <= 1'b0;
        #1;
        cmp(prog_rdata_o, exp);
        cmp({7'h0, prog_hit_o}, {7'h0, hit});
    endtask
    task automatic wr(input logic [21:0] a);
        @(posedge clk_i);
        prog_wr_i <= 1'b1;
        prog_addr_i <= a;
        @(posedge clk_i);
        prog_wr_i <= 1'b0;
        #1;
        cmp({7'h0, wr_ignored_o}, 8'h01);
    endtask
    task automatic chk_all(input logic [63:0] img);
        for (int i = 0; i < 8; i++) begin
            rd({19'h60000, i[2:0]}, img[8*i +: 8] & (i[0] ? 8'h0f : 8'hff), 1'b1);
            cmp(sb[8*i +: 8], img[8*i +: 8] & (i[0] ? 8'h0f : 8'hff));
        end
    endtask
    task automatic do_reset(input logic [3:0] l, input logic m, input logic err);
        int n;
        @(posedge clk_i);
        srst_i <= 1'b1;
        lat <= l;
        mute <= m;
        repeat (4) @(posedge clk_i);
        #1;
        for (int i = 0; i < 8; i++) begin
            cmp(sb[8*i +: 8], i[0] ? 8'h0f : 8'hff);
        end
        cmp({5'h0, load_done_o, cpu_hold_o, load_err_o}, 8'h02);
        @(posedge clk_i);
        srst_i <= 1'b0;
        n = 0;
        while (load_done_o !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        #1;
        cmp({5'h0, load_done_o, cpu_hold_o, load_err_o}, {6'h02, err});
    endtask
    task automatic test_done;
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        test_done;
    end
    initial begin
        srst_i = 1'b1;
        prog_rd_i = 1'b0;
        prog_wr_i = 1'b0;
        prog_addr_i = 22'h000000;
        prog_wdata_i = 8'h00;
        lat = 4'h0;
        mute = 1'b0;
        errors = 0;
        checks_done = 0;
        image = 64'hf43cfa81f75efbc6;
        do_reset(4'h0, 1'b0, 1'b0);
        chk_all(64'hf43cfa81f75efbc6);
        rd(22'h300008, 8'h00, 1'b0);
        rd(22'h2fffff, 8'h00, 1'b0);
        wr(22'h300000);
        wr(22'h300007);
        rd(22'h300000, 8'hc6, 1'b1);
        image <= 64'h9ae107d26b38a41d;
        repeat (40) @(posedge clk_i);
        chk_all(64'hf43cfa81f75efbc6);
        do_reset(4'h5, 1'b0, 1'b0);
        chk_all(64'h9ae107d26b38a41d);
        do_reset(4'h0, 1'b1, 1'b1);
        chk_all(64'hffffffffffffffff);
        test_done;
    end
endmodule

// file: hw/flwl_byte_reader.v
// One flash byte read: address out, strobe held until acknowledge or timeout.
// Assumes a flash port on clk_i that answers with a one-cycle acknowledge.
`include "flwl_regs.vh"

module flwl_byte_reader #(
    parameter FLASH_AW = 20,
    parameter WAIT_MAX = `FLWL_WAIT_MAX
) (
    input  wire                clk_i,
    input  wire                srst_i,
    input  wire                start_i,
    input  wire [FLASH_AW-1:0] addr_i,
    output wire                flash_rd_o,
    output reg  [FLASH_AW-1:0] flash_addr_o,
    input  wire [7:0]          flash_rdata_i,
    input  wire                flash_ack_i,
    output reg  [7:0]          data_o,
    output reg                 done_o,
    output reg                 timeout_o
);

    // ----------------------------------------------------------------
    // Request state and wait counter
    // ----------------------------------------------------------------
    reg                    busy_reg;
    reg [`FLWL_WAIT_W-1:0] wait_reg;

    assign flash_rd_o = busy_reg;

    always @(posedge clk_i) begin
        if (srst_i) begin
            busy_reg     <= 1'b0;
            wait_reg     <= {`FLWL_WAIT_W{1'b0}};
            flash_addr_o <= {FLASH_AW{1'b0}};
            data_o       <= `FLWL_BYTE_RESET;
            done_o       <= 1'b0;
            timeout_o    <= 1'b0;
        end else begin
            done_o    <= 1'b0;
            timeout_o <= 1'b0;
            if (!busy_reg) begin
                if (start_i) begin
                    busy_reg     <= 1'b1;
                    wait_reg     <= {`FLWL_WAIT_W{1'b0}};
                    flash_addr_o <= addr_i;
                end
            end else if (flash_ack_i) begin
                busy_reg <= 1'b0;
                data_o   <= flash_rdata_i;
                done_o   <= 1'b1;
            end else if (wait_reg == WAIT_MAX[`FLWL_WAIT_W-1:0] - 1'b1) begin
                // No answer: byte counts as unprogrammed
                busy_reg  <= 1'b0;
                data_o    <= `FLWL_BYTE_RESET;
                done_o    <= 1'b1;
                timeout_o <= 1'b1;
            end else begin
                wait_reg <= wait_reg + 1'b1;
            end
        end
    end

endmodule

// file: hw/flwl_loader.v
// Flash setup word loader: copies the top eight flash bytes into volatile setup bytes.
// Assumes the flash port and program space read port share clk_i; srst_i covers
// power-up and every device reset.
//
// Function
// RULE_01 - Setup comes from last four flash words, held in volatile registers.
// RULE_02 - Setup bytes are readable in program space from 300000h upward.
// RULE_03 - Load starts by itself right after power-up and every reset.
// RULE_04 - Bytes are filled once per reset; code held off until done.
// RULE_05 - Flash rewrites reach the active bytes only at the next reset.
// RULE_06 - Byte at 300000h+n is loaded from flash byte F8h+n.
// RULE_07 - Upper nibble of each high byte is unimplemented and reads zero.
// RULE_08 - Programmer should set those upper nibbles to ones.
// RULE_09 - Image builder should reserve the setup word locations.
// RULE_10 - Firmware changes setup only by reprogramming the flash words.
// RULE_11 - Bus writes to setup addresses never alter the active bytes.
`include "flwl_regs.vh"

module flwl_loader #(
    parameter FLASH_AW = 20,
    parameter [FLASH_AW-9:0] FCW_PAGE = `FLWL_FCW_PAGE_DEF,
    parameter WAIT_MAX = `FLWL_WAIT_MAX
) (
    input  wire                         clk_i,
    input  wire                         srst_i,
    input  wire                         prog_rd_i,
    input  wire                         prog_wr_i,
    input  wire [`FLWL_PROG_AW-1:0]     prog_addr_i,
    input  wire [7:0]                   prog_wdata_i,
    output reg  [7:0]                   prog_rdata_o,
    output reg                          prog_hit_o,
    output reg                          wr_ignored_o,
    output wire                         flash_rd_o,
    output wire [FLASH_AW-1:0]          flash_addr_o,
    input  wire [7:0]                   flash_rdata_i,
    input  wire                         flash_ack_i,
    output reg                          cpu_hold_o,
    output reg                          load_done_o,
    output reg                          load_err_o,
    output wire [7:0]                   setup_byte_1_low_o,
    output wire [7:0]                   setup_byte_1_high_o,
    output wire [7:0]                   setup_byte_2_low_o,
    output wire [7:0]                   setup_byte_2_high_o,
    output wire [7:0]                   setup_byte_3_low_o,
    output wire [7:0]                   setup_byte_3_high_o,
    output wire [7:0]                   setup_byte_4_low_o,
    output wire [7:0]                   setup_byte_4_high_o
);

    // ----------------------------------------------------------------
    // Load sequencer states
    // ----------------------------------------------------------------
    localparam [3:0] ST_START = 4'b0001;
    localparam [3:0] ST_FETCH = 4'b0010;
    localparam [3:0] ST_NEXT  = 4'b0100;
    localparam [3:0] ST_DONE  = 4'b1000;

    reg  [3:0]              state_reg;
    reg  [3:0]              state_next;
    reg  [`FLWL_IDX_W-1:0]  idx_reg;
    reg  [`FLWL_IDX_W-1:0]  idx_next;
    reg                     start_fetch;
    reg  [63:0]             cfg_reg;
    wire [63:0]             cfg_next;
    wire [7:0]              rd_byte;
    wire                    rd_done;
    wire                    rd_timeout;
    wire [FLASH_AW-1:0]     fetch_addr;
    wire                    addr_hit;
    wire [`FLWL_IDX_W-1:0]  addr_idx;
    wire [7:0]              sel_byte;

    // ----------------------------------------------------------------
    // Flash address of the current byte
    // ----------------------------------------------------------------
    // RULE_06 flash byte order
    assign fetch_addr = {FCW_PAGE, `FLWL_FCW_LOW_BYTE + {5'h00, idx_reg}};

    flwl_byte_reader #(
        .FLASH_AW (FLASH_AW),
        .WAIT_MAX (WAIT_MAX)
    ) u_reader (
        .clk_i         (clk_i),
        .srst_i        (srst_i),
        .start_i       (start_fetch),
        .addr_i        (fetch_addr),
        .flash_rd_o    (flash_rd_o),
        .flash_addr_o  (flash_addr_o),
        .flash_rdata_i (flash_rdata_i),
        .flash_ack_i   (flash_ack_i),
        .data_o        (rd_byte),
        .done_o        (rd_done),
        .timeout_o     (rd_timeout)
    );

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always @* begin
        state_next  = state_reg;
        idx_next    = idx_reg;
        start_fetch = 1'b0;
        case (state_reg)
            // RULE_03 load after reset
            ST_START: begin
                start_fetch = 1'b1;
                state_next  = ST_FETCH;
            end
            ST_FETCH: begin
                if (rd_done) begin
                    state_next = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (idx_reg == `FLWL_NUM_BYTES - 1) begin
                    state_next = ST_DONE;
                end else begin
                    idx_next   = idx_reg + 1'b1;
                    state_next = ST_START;
                end
            end
            // RULE_04 single load
            ST_DONE: begin
                state_next = ST_DONE;
            end
            default: begin
                state_next = ST_START;
                idx_next   = {`FLWL_IDX_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_START;
            idx_reg   <= {`FLWL_IDX_W{1'b0}};
        end else begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
        end
    end

    // ----------------------------------------------------------------
    // Volatile setup bytes
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `FLWL_NUM_BYTES; gi = gi + 1) begin : g_byte
            // RULE_07 high nibble absent
            localparam [7:0] MASK = (gi % 2 == 1) ? `FLWL_HIGH_MASK : `FLWL_LOW_MASK;
            // RULE_01 volatile copy
            assign cfg_next[gi*8 +: 8] =
                (state_reg == ST_FETCH && rd_done && idx_reg == gi) ?
                (rd_byte & MASK) : cfg_reg[gi*8 +: 8];
        end
    endgenerate

    // RULE_05 update only in load
    // RULE_10 no direct firmware path
    always @(posedge clk_i) begin
        if (srst_i) begin
            cfg_reg <= {4{`FLWL_HIGH_MASK, `FLWL_LOW_MASK}};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign setup_byte_1_low_o  = cfg_reg[7:0];
    assign setup_byte_1_high_o = cfg_reg[15:8];
    assign setup_byte_2_low_o  = cfg_reg[23:16];
    assign setup_byte_2_high_o = cfg_reg[31:24];
    assign setup_byte_3_low_o  = cfg_reg[39:32];
    assign setup_byte_3_high_o = cfg_reg[47:40];
    assign setup_byte_4_low_o  = cfg_reg[55:48];
    assign setup_byte_4_high_o = cfg_reg[63:56];

    // ----------------------------------------------------------------
    // Load status and processor hold
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            cpu_hold_o  <= 1'b1;
            load_done_o <= 1'b0;
            load_err_o  <= 1'b0;
        end else begin
            // RULE_04 code waits for load
            cpu_hold_o  <= (state_next != ST_DONE);
            load_done_o <= (state_next == ST_DONE);
            if (rd_timeout) begin
                load_err_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program space access
    // ----------------------------------------------------------------
    // RULE_02 mapped at base
    assign addr_hit = (prog_addr_i[`FLWL_PROG_AW-1:`FLWL_IDX_W] ==
                       `FLWL_CFG_BASE >> `FLWL_IDX_W);
    assign addr_idx = prog_addr_i[`FLWL_IDX_W-1:0];
    assign sel_byte = cfg_reg[addr_idx*8 +: 8];

    always @(posedge clk_i) begin
        if (srst_i) begin
            prog_rdata_o <= `FLWL_READ_ZERO;
            prog_hit_o   <= 1'b0;
            wr_ignored_o <= 1'b0;
        end else begin
            prog_hit_o <= (prog_rd_i | prog_wr_i) & addr_hit;
            if (prog_rd_i && addr_hit) begin
                prog_rdata_o <= sel_byte;
            end else begin
                prog_rdata_o <= `FLWL_READ_ZERO;
            end
            // RULE_11 writes dropped
            wr_ignored_o <= prog_wr_i & addr_hit & (prog_wdata_i == prog_wdata_i);
        end
    end

endmodule

// file: hw/flwl_regs.vh
// Constants of the flash setup word loader: addresses, layout, reset values, counts.
// Assumes inclusion by bare name from the loader and its byte reader.
`ifndef FLWL_REGS_VH
`define FLWL_REGS_VH

// ----------------------------------------------------------------
// Program space map of the volatile setup bytes
// ----------------------------------------------------------------
`define FLWL_PROG_AW          22
`define FLWL_CFG_BASE         22'h300000
`define FLWL_SETUP_1_LOW      22'h300000
`define FLWL_SETUP_1_HIGH     22'h300001
`define FLWL_SETUP_2_LOW      22'h300002
`define FLWL_SETUP_2_HIGH     22'h300003
`define FLWL_SETUP_3_LOW      22'h300004
`define FLWL_SETUP_3_HIGH     22'h300005
`define FLWL_SETUP_4_LOW      22'h300006
`define FLWL_SETUP_4_HIGH     22'h300007
`define FLWL_IDX_W            3
`define FLWL_NUM_BYTES        8

// ----------------------------------------------------------------
// Flash side: low byte of the top eight byte addresses
// ----------------------------------------------------------------
`define FLWL_FCW_LOW_BYTE     8'hf8
`define FLWL_FCW_PAGE_DEF     12'hfff

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define FLWL_LOW_MASK         8'hff
`define FLWL_HIGH_MASK        8'h0f
`define FLWL_BYTE_RESET       8'hff
`define FLWL_READ_ZERO        8'h00

// ----------------------------------------------------------------
// Timing: longest wait for a flash answer, in cycles
// ----------------------------------------------------------------
`define FLWL_WAIT_MAX         16
`define FLWL_WAIT_W           5

`endif
